// ### rtl/smcs_pkg.sv
package smcs_pkg;

    // Register byte addresses on the APB
    localparam logic [7:0] SMCS_CTRL_STATUS_ADDR = 8'hc0;
    localparam logic [7:0] SMCS_CONFIG_ADDR = 8'hc4;
    localparam logic [7:0] SMCS_SHIFT_DATA_ADDR = 8'hc8;
    localparam logic [7:0] SMCS_BIT_ACCESS_ADDR = 8'hcc;

    // Bit positions of smbus_control_status
    localparam int SMCS_CONTROLLER_ROLE_BIT = 7;
    localparam int SMCS_TRANSMIT_DIR_BIT = 6;
    localparam int SMCS_BEGIN_COND_BIT = 5;
    localparam int SMCS_END_COND_BIT = 4;
    localparam int SMCS_RESPONSE_NEEDED_BIT = 3;
    localparam int SMCS_CONTENTION_LOSS_BIT = 2;
    localparam int SMCS_ACK_BIT = 1;
    localparam int SMCS_SERIAL_EVENT_BIT = 0;

    // Config register and bit-access register fields
    localparam int SMCS_AUTO_ACK_BIT = 0;
    localparam int SMCS_BIT_INDEX_LSB = 0;
    localparam int SMCS_BIT_INDEX_MSB = 2;
    localparam int SMCS_BIT_VALUE_POS = 3;

    // Reset values
    localparam logic [7:0] SMCS_CTRL_STATUS_RESET = 8'h00;
    localparam logic SMCS_AUTO_ACK_RESET = 1'b0;
    localparam logic [7:0] SMCS_SHIFT_DATA_RESET = 8'h00;

endpackage

// ### rtl/smcs_sync2.sv
`timescale 1ns/100ps
module smcs_sync2 #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // Idle bus level is high, so both stages reset to ones
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            meta_q <= '1;
            sync_q <= '1;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;

endmodule

// ### rtl/smcs_flags.sv
`timescale 1ns/100ps
module smcs_flags #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Bus pins as sensed
    input wire logic i_scl,
    input wire logic i_sda,
    // Events from the bit engine, one-cycle pulses
    input wire logic i_start_generated,
    input wire logic i_stop_generated,
    input wire logic i_start_detected,
    input wire logic i_rep_start_detected,
    input wire logic i_addr_after_start,
    input wire logic i_stop_detected,
    input wire logic i_byte_received,
    input wire logic i_byte_sent_acked,
    input wire logic i_ack_cycle_done,
    input wire logic i_frame_begin,
    // Engine levels
    input wire logic i_addressed_target,
    input wire logic i_attempt_condition,
    input wire logic i_driving_one,
    input wire logic i_ack_bit_phase,
    // Requests to the bit engine
    output logic o_start_req,
    output logic o_stop_req,
    output logic o_scl_hold,
    output logic o_ack_value,
    output logic o_auto_ack,
    output logic o_resume,
    output logic [7:0] o_shift_data
);

    logic [1:0] pins_s;
    logic scl_s;
    logic sda_s;

    logic role_q;
    logic tx_q;
    logic sta_q;
    logic sto_q;
    logic response_needed_flag_q;
    logic arb_q;
    logic ack_q;
    logic si_q;
    logic start_sw_q;
    logic ack_written_q;
    logic data_written_q;
    logic auto_ack_q;
    logic [7:0] shift_data_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic start_req_q;
    logic stop_req_q;
    logic scl_hold_q;
    logic ack_value_q;
    logic resume_q;

    logic wr_en;
    logic rd_en;
    logic cn_wr;
    logic bit_wr;
    logic [7:0] wmask;
    logic [7:0] wval;
    logic arb_set;
    logic si_event;
    logic si_clear;
    logic sto_set;
    logic [7:0] cn_value;

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] reg_addr);
        addr_hit = (a == ADDR_W'(reg_addr));
    endfunction

    smcs_sync2 #(
        .WIDTH(2)
    ) u_pin_sync (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_async({i_scl, i_sda}),
        .o_sync(pins_s)
    );

    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    // One wait state: pready rises in the second access cycle
    assign wr_en = i_psel & i_penable & pready_q & i_pwrite;
    assign rd_en = i_psel & i_penable & ~pready_q & ~i_pwrite;
    assign cn_wr = wr_en & addr_hit(i_paddr, smcs_pkg::SMCS_CTRL_STATUS_ADDR);
    assign bit_wr = wr_en & addr_hit(i_paddr, smcs_pkg::SMCS_BIT_ACCESS_ADDR);

    // Byte write and single-bit write share one mask path
    always_comb begin
        if (cn_wr) begin
            wmask = 8'hff;
            wval = i_pwdata[7:0];
        end else if (bit_wr) begin
            wmask = 8'h01 << i_pwdata[smcs_pkg::SMCS_BIT_INDEX_MSB:smcs_pkg::SMCS_BIT_INDEX_LSB];
            wval = {8{i_pwdata[smcs_pkg::SMCS_BIT_VALUE_POS]}};
        end else begin
            wmask = 8'h00;
            wval = 8'h00;
        end
    end

    assign arb_set = (i_rep_start_detected & role_q & ~sta_q)
        | (i_attempt_condition & ~scl_s)
        | (i_driving_one & ~i_ack_bit_phase & ~sda_s);
    assign si_event = i_start_generated | arb_set | i_byte_sent_acked | i_byte_received
        | i_addr_after_start | i_stop_detected;
    assign si_clear = wmask[smcs_pkg::SMCS_SERIAL_EVENT_BIT] & ~wval[smcs_pkg::SMCS_SERIAL_EVENT_BIT];
    assign sto_set = i_stop_detected & (i_addressed_target | role_q);

    // Read-only flags never look at wmask, except contention loss, which clears through si_clear
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            role_q <= 1'b0;
        end else if (i_start_generated) begin
            role_q <= 1'b1;
        end else if (i_stop_generated | arb_set) begin
            role_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            tx_q <= 1'b0;
        end else if (i_start_generated | (i_frame_begin & data_written_q)) begin
            tx_q <= 1'b1;
        end else if (i_start_detected | arb_set | i_frame_begin) begin
            tx_q <= 1'b0;
        end
    end

    // A data write arms transmit direction for the next frame only
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            data_written_q <= 1'b0;
        end else if (wr_en & addr_hit(i_paddr, smcs_pkg::SMCS_SHIFT_DATA_ADDR)) begin
            data_written_q <= 1'b1;
        end else if (i_frame_begin) begin
            data_written_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            sta_q <= 1'b0;
        end else if (i_addr_after_start) begin
            sta_q <= 1'b1;
        end else if (wmask[smcs_pkg::SMCS_BEGIN_COND_BIT]) begin
            sta_q <= wval[smcs_pkg::SMCS_BEGIN_COND_BIT];
        end
    end

    // Only a software one requests a START, not a detected one
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            start_sw_q <= 1'b0;
        end else if (wmask[smcs_pkg::SMCS_BEGIN_COND_BIT]) begin
            start_sw_q <= wval[smcs_pkg::SMCS_BEGIN_COND_BIT];
        end else if (i_start_generated) begin
            start_sw_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            sto_q <= 1'b0;
        end else if (sto_set) begin
            sto_q <= 1'b1;
        end else if (wmask[smcs_pkg::SMCS_END_COND_BIT]) begin
            sto_q <= wval[smcs_pkg::SMCS_END_COND_BIT];
        end else if (i_stop_generated) begin
            sto_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            response_needed_flag_q <= 1'b0;
        end else if (i_byte_received & ~auto_ack_q) begin
            response_needed_flag_q <= 1'b1;
        end else if (i_ack_cycle_done) begin
            response_needed_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            arb_q <= 1'b0;
        end else if (arb_set) begin
            arb_q <= 1'b1;
        end else if (si_clear) begin
            arb_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            ack_written_q <= 1'b0;
        end else if (wmask[smcs_pkg::SMCS_ACK_BIT]) begin
            ack_written_q <= 1'b1;
        end else if (i_byte_received) begin
            ack_written_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            ack_q <= 1'b0;
        end else if (i_ack_cycle_done & tx_q) begin
            ack_q <= ~sda_s;
        end else if (wmask[smcs_pkg::SMCS_ACK_BIT]) begin
            ack_q <= wval[smcs_pkg::SMCS_ACK_BIT];
        end else if (si_clear & response_needed_flag_q & ~ack_written_q) begin
            ack_q <= 1'b0;
        end
    end

    // Hardware set beats a software clear in the same cycle
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            si_q <= 1'b0;
        end else if (si_event | (wmask[smcs_pkg::SMCS_SERIAL_EVENT_BIT] & wval[smcs_pkg::SMCS_SERIAL_EVENT_BIT])) begin
            si_q <= 1'b1;
        end else if (si_clear) begin
            si_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            auto_ack_q <= smcs_pkg::SMCS_AUTO_ACK_RESET;
        end else if (wr_en & addr_hit(i_paddr, smcs_pkg::SMCS_CONFIG_ADDR)) begin
            auto_ack_q <= i_pwdata[smcs_pkg::SMCS_AUTO_ACK_BIT];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            shift_data_q <= smcs_pkg::SMCS_SHIFT_DATA_RESET;
        end else if (wr_en & addr_hit(i_paddr, smcs_pkg::SMCS_SHIFT_DATA_ADDR)) begin
            shift_data_q <= i_pwdata[7:0];
        end
    end

    // Engine requests; the engine runs STOP before START when both are up
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            start_req_q <= 1'b0;
            stop_req_q <= 1'b0;
            scl_hold_q <= 1'b0;
            ack_value_q <= 1'b0;
            resume_q <= 1'b0;
        end else begin
            start_req_q <= start_sw_q;
            stop_req_q <= sto_q & role_q;
            scl_hold_q <= si_q;
            ack_value_q <= ack_q;
            resume_q <= si_clear & si_q & ~si_event;
        end
    end

    assign cn_value = {role_q, tx_q, sta_q, sto_q, response_needed_flag_q, arb_q, ack_q, si_q};

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= i_psel & i_penable & ~pready_q;
            pslverr_q <= i_psel & i_penable & ~pready_q
                & ~addr_hit(i_paddr, smcs_pkg::SMCS_CTRL_STATUS_ADDR)
                & ~addr_hit(i_paddr, smcs_pkg::SMCS_CONFIG_ADDR)
                & ~addr_hit(i_paddr, smcs_pkg::SMCS_SHIFT_DATA_ADDR)
                & ~addr_hit(i_paddr, smcs_pkg::SMCS_BIT_ACCESS_ADDR);
            if (rd_en & addr_hit(i_paddr, smcs_pkg::SMCS_CTRL_STATUS_ADDR)) begin
                prdata_q <= {24'h00_0000, cn_value};
            end else if (rd_en & addr_hit(i_paddr, smcs_pkg::SMCS_CONFIG_ADDR)) begin
                prdata_q <= {31'h0000_0000, auto_ack_q};
            end else if (rd_en & addr_hit(i_paddr, smcs_pkg::SMCS_SHIFT_DATA_ADDR)) begin
                prdata_q <= {24'h00_0000, shift_data_q};
            end else if (rd_en) begin
                prdata_q <= 32'h0000_0000;
            end
        end
    end

    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;
    assign o_start_req = start_req_q;
    assign o_stop_req = stop_req_q;
    assign o_scl_hold = scl_hold_q;
    assign o_ack_value = ack_value_q;
    assign o_auto_ack = auto_ack_q;
    assign o_resume = resume_q;
    assign o_shift_data = shift_data_q;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    a_role_start: assert property (i_start_generated |=> role_q ##1 o_stop_req == $past(sto_q & role_q))
        else $error("role flag not set after START");
    a_tx_start: assert property (i_start_generated |=> tx_q)
        else $error("direction flag not set after START");
    a_sta_hold: assert property (sta_q && !wmask[smcs_pkg::SMCS_BEGIN_COND_BIT] |=> sta_q)
        else $error("begin flag cleared by hardware");
    a_start_req: assert property (cn_wr && i_pwdata[smcs_pkg::SMCS_BEGIN_COND_BIT] |=> ##1 o_start_req)
        else $error("START request missing");
    a_sto_clear: assert property (i_stop_generated && !sto_set && !wmask[smcs_pkg::SMCS_END_COND_BIT]
        |=> !sto_q)
        else $error("end flag not cleared after STOP");
    a_response_needed_flag_auto: assert property (i_byte_received && auto_ack_q && !response_needed_flag_q |=> !response_needed_flag_q)
        else $error("response needed set with auto ack");
    a_response_needed_flag_done: assert property (i_ack_cycle_done && !i_byte_received |=> !response_needed_flag_q)
        else $error("response needed not cleared");
    a_arb_sda: assert property (i_driving_one && !i_ack_bit_phase && !sda_s
        |=> arb_q && si_q ##1 o_scl_hold)
        else $error("contention on SDA missed");
    a_arb_clear: assert property (si_clear && !arb_set |=> !arb_q)
        else $error("contention flag survived event clear");
    a_nack_default: assert property (si_clear && response_needed_flag_q && !ack_written_q && !wmask[1] && !i_ack_cycle_done
        |=> ##1 !o_ack_value)
        else $error("default NACK not applied");
    a_si_stall: assert property (si_q |=> o_scl_hold)
        else $error("SCL not held while event pending");
    a_resume_pulse: assert property (si_clear && si_q && !si_event |=> o_resume ##1 !o_resume)
        else $error("resume pulse wrong");
    a_ro_ignore: assert property (cn_wr && !i_start_generated && !i_stop_generated && !arb_set
        |=> role_q == $past(role_q))
        else $error("role flag changed by software");

    c_arb_lost: cover property (arb_set ##1 si_q);
    c_stop_start: cover property (o_stop_req && o_start_req);
    c_default_nack: cover property (si_clear && response_needed_flag_q && !ack_written_q);
    c_bit_write: cover property (bit_wr ##2 o_start_req);

endmodule

// ### testbench/smcs_engine_model.sv
`timescale 1ns/100ps
module smcs_engine_model #(
    parameter int GEN_DELAY = 3
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Requests from the flag block
    input wire logic i_start_req,
    input wire logic i_stop_req,
    input wire logic i_scl_hold,
    // Bench controls
    input wire logic [9:0] i_ev_req,
    input wire logic i_sda_low,
    input wire logic i_scl_low,
    // Engine events and sensed pins
    output logic [9:0] o_ev,
    output logic o_scl,
    output logic o_sda
);
    logic [3:0] cnt_q;
    logic busy_q;
    logic arm_q;
    logic stop_q;

    // Pull-ups: released lines read high
    assign o_sda = ~i_sda_low;
    assign o_scl = ~(i_scl_low | i_scl_hold);

    // Stop is served before start when both are asked for
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_ev <= 10'h000;
            cnt_q <= 4'h0;
            busy_q <= 1'b0;
            arm_q <= 1'b1;
            stop_q <= 1'b0;
        end else begin
            o_ev <= i_ev_req;
            // Re-arm once the request just served drops, so a START queued behind a STOP still runs
            if (!busy_q && !(stop_q ? i_stop_req : i_start_req)) begin
                arm_q <= 1'b1;
            end
            if (busy_q) begin
                if (cnt_q == 4'h0) begin
                    busy_q <= 1'b0;
                    o_ev[stop_q ? 1 : 0] <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 4'h1;
                end
            end else if (arm_q && !i_scl_hold && (i_start_req || i_stop_req)) begin
                busy_q <= 1'b1;
                arm_q <= 1'b0;
                stop_q <= i_stop_req;
                cnt_q <= 4'(GEN_DELAY);
            end
        end
    end
endmodule

// ### testbench/tb_smbus_control_status_flags.sv
`timescale 1ns/100ps
module tb_smbus_control_status_flags;
    logic clk, rst, psel, pen, pwrite, pready, pslverr, scl, sda;
    logic [7:0] paddr, shift_data;
    logic [31:0] pwdata, prdata;
    logic [9:0] ev, ev_req;
    logic addressed, attempt, drv1, ackph, sda_low, scl_low;
    logic start_req, stop_req, scl_hold, ack_value, auto_ack, resume;
    int errors, check_count;
    int resume_count = 0;

    smcs_flags u_dut (.i_clk_sys(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_scl(scl), .i_sda(sda), .i_start_generated(ev[0]), .i_stop_generated(ev[1]),
        .i_start_detected(ev[2]), .i_rep_start_detected(ev[3]), .i_addr_after_start(ev[4]),
        .i_stop_detected(ev[5]), .i_byte_received(ev[6]), .i_byte_sent_acked(ev[7]),
        .i_ack_cycle_done(ev[8]), .i_frame_begin(ev[9]), .i_addressed_target(addressed),
        .i_attempt_condition(attempt), .i_driving_one(drv1), .i_ack_bit_phase(ackph),
        .o_start_req(start_req), .o_stop_req(stop_req), .o_scl_hold(scl_hold), .o_ack_value(ack_value),
        .o_auto_ack(auto_ack), .o_resume(resume), .o_shift_data(shift_data));

    smcs_engine_model u_eng (.i_clk_sys(clk), .i_rst(rst), .i_start_req(start_req), .i_stop_req(stop_req),
        .i_scl_hold(scl_hold), .i_ev_req(ev_req), .i_sda_low(sda_low), .i_scl_low(scl_low),
        .o_ev(ev), .o_scl(scl), .o_sda(sda));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Counted at the falling edge, where the one-cycle pulse is settled
    always @(negedge clk) begin
        if (resume === 1'b1) begin
            resume_count <= resume_count + 1;
        end
    end

    task automatic test_done;
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Request held until pready is seen high at a rising edge; data taken at that edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        r = 32'h0;
        e = 1'b0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            errors++;
            test_done();
        end else begin
            r = prdata;
            e = pslverr;
            psel <= 1'b0;
            pen <= 1'b0;
            // One idle edge, so a following call never reassigns psel in this time step
            @(posedge clk);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r & m, exp);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic pulse(input int k);
        ev_req <= 10'h001 << k;
        @(posedge clk);
        ev_req <= 10'h000;
        idle(3);
    endtask

    task automatic wait_hold(input logic v);
        int n;
        n = 0;
        while (scl_hold !== v && n < 50) begin
            @(negedge clk);
            n++;
        end
        if (scl_hold !== v) begin
            errors++;
            test_done();
        end else begin
            @(posedge clk);
        end
    endtask

    task automatic t_regs;
        logic [31:0] r;
        logic e;
        rd(8'hc0, 32'hffffffff, 32'h0);
        rd(8'hc4, 32'hffffffff, 32'h0);
        apb(1'b0, 8'hd0, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        wr(8'hc8, 32'ha5);
        chk({24'h0, shift_data}, 32'ha5);
        wr(8'hc0, 32'hce);
        idle(2);
        rd(8'hc0, 32'hff, 32'h02);
        chk({31'h0, ack_value}, 32'h1);
        wr(8'hc0, 32'h0);
    endtask

    task automatic do_start;
        wr(8'hc0, 32'h20);
        wait_hold(1'b1);
    endtask

    task automatic t_start_stop;
        int n;
        do_start();
        rd(8'hc0, 32'hf5, 32'he1);
        chk({31'h0, scl}, 32'h0);
        n = resume_count;
        wr(8'hc0, 32'h0);
        idle(2);
        chk({31'h0, scl_hold}, 32'h0);
        chk(32'(resume_count - n), 32'h1);
        // Both requests at once: a START last leaves the role flag set
        wr(8'hc0, 32'h30);
        idle(2);
        wait_hold(1'b1);
        rd(8'hc0, 32'hb1, 32'ha1);
        wr(8'hc0, 32'h0);
        wr(8'hc0, 32'h10);
        idle(10);
        rd(8'hc0, 32'h90, 32'h0);
    endtask

    task automatic t_arb;
        ackph <= 1'b1;
        drv1 <= 1'b1;
        sda_low <= 1'b1;
        idle(5);
        rd(8'hc0, 32'h04, 32'h0);
        ackph <= 1'b0;
        drv1 <= 1'b0;
        sda_low <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            do_start();
            wr(8'hc0, 32'h0);
            idle(2);
            if (k == 0) pulse(3);
            if (k == 1) {attempt, scl_low} <= 2'b11;
            if (k == 2) {drv1, sda_low} <= 2'b11;
            idle(5);
            rd(8'hc0, 32'hc5, 32'h05);
            {attempt, scl_low, drv1, sda_low} <= 4'h0;
            idle(4);
            wr(8'hc0, 32'h0);
            rd(8'hc0, 32'h04, 32'h0);
        end
    endtask

    task automatic t_rx;
        // Ack bit preset to one, so the default NACK is visible
        wr(8'hcc, 32'h9);
        pulse(6);
        rd(8'hc0, 32'h0b, 32'h0b);
        chk({31'h0, scl_hold}, 32'h1);
        wr(8'hcc, 32'h0);
        idle(2);
        rd(8'hc0, 32'h0b, 32'h08);
        chk({31'h0, ack_value}, 32'h0);
        pulse(8);
        rd(8'hc0, 32'h08, 32'h0);
        wr(8'hc4, 32'h1);
        wr(8'hcc, 32'h9);
        pulse(6);
        rd(8'hc0, 32'h0b, 32'h03);
        chk({30'h0, ack_value, auto_ack}, 32'h3);
        wr(8'hcc, 32'h0);
        rd(8'hc0, 32'h01, 32'h0);
        wr(8'hc4, 32'h0);
    endtask

    task automatic t_target;
        addressed <= 1'b1;
        pulse(4);
        rd(8'hc0, 32'h21, 32'h21);
        wr(8'hcc, 32'h0);
        rd(8'hc0, 32'h21, 32'h20);
        pulse(5);
        rd(8'hc0, 32'h11, 32'h11);
        wr(8'hc0, 32'h0);
        addressed <= 1'b0;
    endtask

    task automatic t_tx;
        wr(8'hc8, 32'h5a);
        pulse(9);
        rd(8'hc0, 32'h40, 32'h40);
        sda_low <= 1'b1;
        idle(4);
        pulse(8);
        rd(8'hc0, 32'h02, 32'h02);
        sda_low <= 1'b0;
        idle(4);
        pulse(8);
        rd(8'hc0, 32'h02, 32'h0);
        pulse(9);
        rd(8'hc0, 32'h40, 32'h0);
        pulse(7);
        rd(8'hc0, 32'h01, 32'h01);
        wr(8'hc0, 32'h0);
        wr(8'hc0, 32'h01);
        wait_hold(1'b1);
        wr(8'hc0, 32'h0);
        wait_hold(1'b0);
    endtask

    initial begin
        errors = 0;
        check_count = 0;
        rst = 1'b1;
        {psel, pen, pwrite, paddr, pwdata} = '0;
        {ev_req, addressed, attempt, drv1, ackph, sda_low, scl_low} = '0;
        idle(3);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_start_stop();
        t_arb();
        t_rx();
        t_target();
        t_tx();
        test_done();
    end
endmodule
